// >>> logic/saf_pkg.sv
/*
  Constants, types and helpers shared by the SONET receive alignment block.
  Assumes one system clock; channel words arrive qualified by a valid strobe.
*/
package saf_pkg;
  localparam int SAF_NCH = 8;
  localparam int SAF_NGRP = 4;
  localparam int SAF_DEPTH = 24;
  localparam int SAF_DW = 32;
  localparam int SAF_BYTE_HI = 31;
  localparam int SAF_BYTE_LO = 24;
  localparam logic [4:0] SAF_FIRST = 5'h00;
  localparam logic [4:0] SAF_MID = 5'h0c;
  localparam logic [4:0] SAF_LAST = 5'h17;
  localparam logic [4:0] SAF_SYNC_INIT = 5'h12;
  localparam logic [4:0] SAF_STEP1 = 5'h01;
  localparam logic [4:0] SAF_STEP2 = 5'h02;
  localparam logic [1:0] SAF_M_NONE = 2'h0;
  localparam logic [1:0] SAF_M_TWIN = 2'h1;
  localparam logic [1:0] SAF_M_BLOCK = 2'h2;
  localparam logic [1:0] SAF_M_OCTAL = 2'h3;
  localparam logic [2:0] SAF_BASE_TWIN = 3'h0;
  localparam logic [2:0] SAF_BASE_BLOCK = 3'h4;
  localparam logic [2:0] SAF_BASE_OCTAL = 3'h6;
  localparam logic [3:0] SAF_R_CTRL = 4'h0;
  localparam logic [3:0] SAF_R_STREN = 4'h1;
  localparam logic [3:0] SAF_R_RSGRP = 4'h2;
  localparam logic [3:0] SAF_R_RSCH = 4'h3;
  localparam logic [3:0] SAF_R_FMIN = 4'h4;
  localparam logic [3:0] SAF_R_GROUP_OVERFLOW_FLAG = 4'h5;
  localparam logic [3:0] SAF_R_OOS = 4'h6;
  localparam logic [3:0] SAF_R_SYNCST = 4'h7;
  localparam logic [7:0] SAF_STREN_RST = 8'hff;
  localparam logic [4:0] SAF_FMIN_RST = 5'h04;
  localparam logic [10:0] SAF_TOH_WORDS = 11'h024;
  localparam logic [10:0] SAF_COL_LAST = 11'h437;
  localparam logic [10:0] SAF_H2_COL = 11'h00c;
  localparam logic [10:0] SAF_H3_COL = 11'h018;
  localparam logic [3:0] SAF_ROW_LAST = 4'h8;
  localparam logic [3:0] SAF_PTR_ROW = 4'h3;
  localparam logic [3:0] SAF_STS_LAST = 4'hb;
  localparam logic [9:0] SAF_I_MASK = 10'h2aa;
  localparam logic [9:0] SAF_D_MASK = 10'h155;
  localparam logic [3:0] SAF_JUST_VOTE = 4'h3;

  typedef struct packed {
    logic fp;
    logic [SAF_DW-1:0] data;
  } saf_word_s;

  typedef struct packed {
    logic bypass;
    logic just_en;
    logic [1:0] mode;
  } saf_ctrl_s;

  typedef enum logic [1:0] {SY_IDLE, SY_RUN, SY_DONE} saf_sync_e;

  function automatic logic [4:0] saf_inc(input logic [4:0] p);
    saf_inc = (p == SAF_LAST) ? SAF_FIRST : 5'(p + SAF_STEP1);
  endfunction : saf_inc

  // Group of a channel; twin pairs stay inside one serial block
  function automatic logic [1:0] saf_grp(input logic [1:0] m,
                                         input logic [2:0] c);
    saf_grp = (m == SAF_M_TWIN) ? c[2:1] :
              (m == SAF_M_BLOCK) ? {1'b0, c[2]} : 2'h0;
  endfunction : saf_grp

  function automatic logic [2:0] saf_base(input logic [1:0] m);
    saf_base = (m == SAF_M_TWIN) ? SAF_BASE_TWIN :
               (m == SAF_M_BLOCK) ? SAF_BASE_BLOCK : SAF_BASE_OCTAL;
  endfunction : saf_base

  function automatic logic [3:0] saf_votes(input logic [9:0] x);
    saf_votes = 4'h0;
    for (int i = 0; i < 10; i++) begin
      saf_votes = 4'(saf_votes + {3'h0, x[i]});
    end
  endfunction : saf_votes
endpackage : saf_pkg

// >>> logic/saf_align_buf.sv
/*
  One channel alignment buffer: flip-flop storage with write and read
  pointers. Assumes the caller paces reads and issues pointer loads.
*/
module saf_align_buf
  import saf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_valid,
  input wire saf_word_s wr_word,
  input wire logic wr_restart,
  input wire logic rd_en,
  input wire logic rd_load,
  input wire logic [4:0] rd_load_ptr,
  output logic rd_valid,
  output saf_word_s rd_word,
  output logic [4:0] rd_ptr
);
  saf_word_s mem_q [SAF_DEPTH];
  logic [4:0] wptr_q;
  wire [4:0] wr_addr = wr_restart ? SAF_FIRST : wptr_q;

  always_ff @(posedge clk) begin
    if (wr_valid) begin
      mem_q[wr_addr] <= wr_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_q <= SAF_FIRST;
      rd_ptr <= SAF_FIRST;
      rd_valid <= 1'b0;
      rd_word <= '0;
    end else begin
      if (wr_valid) begin
        wptr_q <= saf_inc(wr_addr);
      end
      rd_valid <= rd_en && !rd_load;
      if (rd_load) begin
        rd_ptr <= rd_load_ptr;
      end else if (rd_en) begin
        rd_ptr <= saf_inc(rd_ptr);
        rd_word <= mem_q[rd_ptr];
      end
    end
  end

  property p_first_at_zero;
    @(posedge clk) disable iff (rst)
    (wr_valid && wr_restart) |=> (mem_q[0] == $past(wr_word));
  endproperty
  a_first_at_zero: assert property (p_first_at_zero)
    else $error("framing word not stored at entry zero");
endmodule : saf_align_buf

// >>> logic/saf_spe_gen.sv
/*
  Payload envelope generator for one channel: frame position counters,
  optional justification tracking and retimed output.
*/
module saf_spe_gen
  import saf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire saf_word_s in_word,
  input wire logic just_en,
  output logic out_valid,
  output logic out_fp,
  output logic out_spe,
  output logic [SAF_DW-1:0] out_data
);
  logic [10:0] col_q;
  logic [3:0] row_q;
  logic [3:0] sts_q;
  logic [1:0] h1_q;
  logic [9:0] ptr_q;
  logic pos_q;
  logic neg_q;

  wire [10:0] col = in_word.fp ? 11'h000 : col_q;
  wire [3:0] row = in_word.fp ? 4'h0 : row_q;
  wire [3:0] sts = in_word.fp ? 4'h0 : sts_q;
  wire ptr_row = row == SAF_PTR_ROW;
  wire at_h1 = ptr_row && col < SAF_H2_COL && sts == 4'h0;
  wire at_h2 = ptr_row && col == SAF_H2_COL;
  wire in_h3 = ptr_row && col >= SAF_H3_COL && col < SAF_TOH_WORDS;
  wire after_h3 = ptr_row && col == SAF_TOH_WORDS;
  wire [7:0] top = in_word.data[SAF_BYTE_HI:SAF_BYTE_LO];
  wire [9:0] ptr_n = {h1_q, top};
  wire [9:0] flip = ptr_n ^ ptr_q;
  // Only the increment and decrement bits are voted; no pointer is interpreted
  wire pos_n = saf_votes(flip & SAF_I_MASK) >= SAF_JUST_VOTE;
  wire neg_n = saf_votes(flip & SAF_D_MASK) >= SAF_JUST_VOTE;
  wire transport_overhead = col < SAF_TOH_WORDS;
  wire spe = in_h3 ? (just_en && neg_q) :
             after_h3 ? !(just_en && pos_q) : !transport_overhead;

  always_ff @(posedge clk) begin
    if (rst) begin
      col_q <= 11'h000;
      row_q <= 4'h0;
      sts_q <= 4'h0;
      h1_q <= 2'h0;
      ptr_q <= 10'h000;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (in_valid) begin
      col_q <= (col == SAF_COL_LAST) ? 11'h000 : 11'(col + 11'h001);
      if (col == SAF_COL_LAST) begin
        row_q <= (row == SAF_ROW_LAST) ? 4'h0 : 4'(row + 4'h1);
      end else begin
        row_q <= row;
      end
      sts_q <= (sts == SAF_STS_LAST) ? 4'h0 : 4'(sts + 4'h1);
      if (at_h1) begin
        h1_q <= in_word.data[SAF_BYTE_LO+1:SAF_BYTE_LO];
      end
      if (at_h2) begin
        pos_q <= pos_n;
        neg_q <= neg_n;
        if (!pos_n && !neg_n) begin
          ptr_q <= ptr_n;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_fp <= 1'b0;
      out_spe <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_fp <= in_word.fp;
        out_spe <= spe;
        out_data <= in_word.data;
      end
    end
  end

  property p_toh_low;
    @(posedge clk) disable iff (rst)
    (in_valid && transport_overhead && !in_h3) |=> (out_valid && !out_spe);
  endproperty
  a_toh_low: assert property (p_toh_low)
    else $error("indicator high during overhead");

  property p_pos_just;
    @(posedge clk) disable iff (rst)
    (in_valid && after_h3 && just_en && pos_q) |=> !out_spe;
  endproperty
  a_pos_just: assert property (p_pos_just)
    else $error("byte after H3 not low on positive justification");
endmodule : saf_spe_gen

// >>> logic/saf_align_top.sv
/*
  Receive multi-channel alignment: eight channel buffers, group sync
  engines, status flags, register port and payload generators.
  Assumes channel words arrive on CLK_SYS qualified by a valid strobe.
*/
module saf_align_top
  import saf_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic [SAF_NCH-1:0] RX_WORD_VALID,
  input wire logic [SAF_NCH-1:0] RX_FRAME_MARK,
  input wire logic [SAF_NCH*SAF_DW-1:0] RX_WORD_DATA,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic [SAF_NCH-1:0] OUT_VALID,
  output logic [SAF_NCH-1:0] FRAME_MARKER_OUT,
  output logic [SAF_NCH-1:0] PAYLOAD_INDICATOR_OUT,
  output logic [SAF_NCH*SAF_DW-1:0] OUT_DATA,
  output logic [6:0] GROUP_OVERFLOW_FLAG,
  output logic [6:0] GROUP_OUT_OF_SYNC_FLAG
);
  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  saf_ctrl_s ctrl_q;
  logic [7:0] str_en_q;
  logic [6:0] rs_grp_q;
  logic [6:0] rs_grp_prev_q;
  logic [7:0] rs_ch_q;
  logic [7:0] rs_ch_prev_q;
  logic [4:0] fmin_q;
  logic [7:0] arm_q;
  logic [7:0] reading_q;
  logic [7:0] group_overflow_flag_set;
  logic [7:0] oos_set;
  logic [7:0] oos_clr;

  wire wr_ctrl = REG_WR && REG_ADDR == SAF_R_CTRL;
  wire wr_stren = REG_WR && REG_ADDR == SAF_R_STREN;
  wire wr_rsgrp = REG_WR && REG_ADDR == SAF_R_RSGRP;
  wire wr_rsch = REG_WR && REG_ADDR == SAF_R_RSCH;
  wire wr_fmin = REG_WR && REG_ADDR == SAF_R_FMIN;
  wire wr_group_overflow_flag = REG_WR && REG_ADDR == SAF_R_GROUP_OVERFLOW_FLAG;
  wire wr_oos = REG_WR && REG_ADDR == SAF_R_OOS;
  wire [6:0] group_overflow_flag_w1c = wr_group_overflow_flag ? REG_WDATA[6:0] : 7'h00;
  wire [6:0] oos_w1c = wr_oos ? REG_WDATA[6:0] : 7'h00;

  wire [31:0] rd_mux =
    (REG_ADDR == SAF_R_CTRL) ? {28'h0, ctrl_q} :
    (REG_ADDR == SAF_R_STREN) ? {24'h0, str_en_q} :
    (REG_ADDR == SAF_R_RSGRP) ? {25'h0, rs_grp_q} :
    (REG_ADDR == SAF_R_RSCH) ? {24'h0, rs_ch_q} :
    (REG_ADDR == SAF_R_FMIN) ? {27'h0, fmin_q} :
    (REG_ADDR == SAF_R_GROUP_OVERFLOW_FLAG) ? {25'h0, GROUP_OVERFLOW_FLAG} :
    (REG_ADDR == SAF_R_OOS) ? {25'h0, GROUP_OUT_OF_SYNC_FLAG} :
    (REG_ADDR == SAF_R_SYNCST) ? {16'h0, arm_q, reading_q} : 32'h0;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ctrl_q <= '0;
      str_en_q <= SAF_STREN_RST;
      rs_grp_q <= 7'h00;
      rs_ch_q <= 8'h00;
      fmin_q <= SAF_FMIN_RST;
      REG_RDATA <= 32'h0;
    end else begin
      if (wr_ctrl) ctrl_q <= REG_WDATA[3:0];
      if (wr_stren) str_en_q <= REG_WDATA[7:0];
      if (wr_rsgrp) rs_grp_q <= REG_WDATA[6:0];
      if (wr_rsch) rs_ch_q <= REG_WDATA[7:0];
      if (wr_fmin) fmin_q <= REG_WDATA[4:0];
      REG_RDATA <= REG_RD ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // Status flags: hardware set wins over software clear
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rs_grp_prev_q <= 7'h00;
      rs_ch_prev_q <= 8'h00;
      GROUP_OVERFLOW_FLAG <= 7'h00;
      GROUP_OUT_OF_SYNC_FLAG <= 7'h00;
    end else begin
      rs_grp_prev_q <= rs_grp_q;
      rs_ch_prev_q <= rs_ch_q;
      GROUP_OVERFLOW_FLAG <= (GROUP_OVERFLOW_FLAG & ~group_overflow_flag_w1c)
                             | group_overflow_flag_set[6:0];
      GROUP_OUT_OF_SYNC_FLAG <= (GROUP_OUT_OF_SYNC_FLAG & ~oos_w1c
                                 & ~oos_clr[6:0]) | oos_set[6:0];
    end
  end

  // ---------------------------------------------------------------
  // Shared decode
  // ---------------------------------------------------------------
  wire [1:0] mode = ctrl_q.mode;
  wire grouped = mode != SAF_M_NONE;
  wire [2:0] base = saf_base(mode);
  wire [6:0] rs_grp_rise = rs_grp_q & ~rs_grp_prev_q;
  wire [7:0] rs_ch_rise = rs_ch_q & ~rs_ch_prev_q;
  wire [7:0] mark = RX_WORD_VALID & RX_FRAME_MARK;

  logic [7:0] members [SAF_NGRP];
  logic [7:0] hits [SAF_NGRP];
  logic [7:0] seen_n [SAF_NGRP];
  logic [2:0] sidx [SAF_NGRP];
  logic [3:0] eng_rs;
  logic [3:0] all_in;
  logic [3:0] fin;
  logic [3:0] start;
  logic [3:0] oos_hit;
  logic [4:0] cnt_n [SAF_NGRP];
  saf_sync_e st_q [SAF_NGRP];
  logic [4:0] cnt_q [SAF_NGRP];
  logic [7:0] seen_q [SAF_NGRP];
  logic [1:0] grp_c [SAF_NCH];
  logic [4:0] rd_ptr [SAF_NCH];
  logic [7:0] indep_load;
  logic [7:0] rd_load;

  // ---------------------------------------------------------------
  // Group sync engines
  // ---------------------------------------------------------------
  for (genvar g = 0; g < SAF_NGRP; g++) begin : g_eng
    wire eng_ok = grouped && (g == 0 || mode == SAF_M_TWIN ||
                              (mode == SAF_M_BLOCK && g < 2));
    assign sidx[g] = 3'(base + 3'(g));
    assign eng_rs[g] = eng_ok && rs_grp_rise[sidx[g]];
    for (genvar c = 0; c < SAF_NCH; c++) begin : g_mem
      // Disabled members drop out without touching others
      assign members[g][c] = grouped && str_en_q[c]
                             && grp_c[c] == 2'(g);
    end
    assign hits[g] = mark & members[g];
    assign seen_n[g] = seen_q[g] | hits[g];
    assign all_in[g] = members[g] != 8'h00
                       && (seen_n[g] & members[g]) == members[g];
    assign cnt_n[g] = (st_q[g] != SY_RUN) ? cnt_q[g] :
                      !all_in[g] ? 5'(cnt_q[g] - SAF_STEP1) :
                      (cnt_q[g] <= SAF_STEP2) ? 5'h00 :
                      5'(cnt_q[g] - SAF_STEP2);
    assign fin[g] = st_q[g] == SY_RUN && cnt_n[g] == 5'h00;
    assign start[g] = fin[g] && all_in[g];
    assign oos_hit[g] = fin[g] && !all_in[g];

    always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || eng_rs[g]) begin
        st_q[g] <= SY_IDLE;
        cnt_q[g] <= 5'h00;
        seen_q[g] <= 8'h00;
      end else begin
        case (st_q[g])
          SY_IDLE: begin
            if (hits[g] != 8'h00) begin
              st_q[g] <= SY_RUN;
              cnt_q[g] <= SAF_SYNC_INIT;
              seen_q[g] <= hits[g];
            end
          end
          SY_RUN: begin
            cnt_q[g] <= cnt_n[g];
            seen_q[g] <= seen_n[g];
            if (fin[g]) st_q[g] <= SY_DONE;
          end
          SY_DONE: st_q[g] <= SY_DONE;
          default: st_q[g] <= SY_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    oos_set = 8'h00;
    oos_clr = 8'h00;
    group_overflow_flag_set = 8'h00;
    for (int g = 0; g < SAF_NGRP; g++) begin
      if (oos_hit[g]) oos_set[sidx[g]] = 1'b1;
      if (eng_rs[g]) oos_clr[sidx[g]] = 1'b1;
    end
    for (int c = 0; c < SAF_NCH; c++) begin
      if (grouped && mark[c] && reading_q[c] && rd_ptr[c] < fmin_q)
        group_overflow_flag_set[sidx[grp_c[c]]] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Channels: buffer, read control, payload generator
  // ---------------------------------------------------------------
  for (genvar c = 0; c < SAF_NCH; c++) begin : g_ch
    wire [2:0] cid = 3'(c);
    // Read pacing from the group's base channel stands in for the
    // shared read clock; that channel must stay powered
    wire [2:0] lead = (mode == SAF_M_TWIN) ? {cid[2:1], 1'b0} :
                      (mode == SAF_M_BLOCK) ? {cid[2], 2'b00} :
                      (mode == SAF_M_OCTAL) ? 3'h0 : cid;
    wire pace = RX_WORD_VALID[lead];
    wire rearm = rs_ch_rise[c] || (grouped && eng_rs[grp_c[c]]);
    wire grp_load = grouped && start[grp_c[c]] && members[grp_c[c]][c];
    wire rd_en = reading_q[c] && pace && !rd_load[c];
    saf_word_s in_w;
    saf_word_s buf_w;
    logic buf_v;

    assign grp_c[c] = saf_grp(mode, cid);
    assign in_w = {RX_FRAME_MARK[c], RX_WORD_DATA[c*SAF_DW +: SAF_DW]};
    assign indep_load[c] = !grouped && arm_q[c] && mark[c];
    assign rd_load[c] = indep_load[c] || grp_load;

    always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
        arm_q[c] <= 1'b1;
        reading_q[c] <= 1'b0;
      end else begin
        if (rearm) arm_q[c] <= 1'b1;
        else if (mark[c]) arm_q[c] <= 1'b0;
        if (rearm) reading_q[c] <= 1'b0;
        else if (rd_load[c]) reading_q[c] <= 1'b1;
      end
    end

    saf_align_buf u_buf (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .wr_valid(RX_WORD_VALID[c]),
      .wr_word(in_w),
      .wr_restart(arm_q[c] && mark[c]),
      .rd_en(rd_en),
      .rd_load(rd_load[c]),
      .rd_load_ptr(grouped ? SAF_FIRST : SAF_MID),
      .rd_valid(buf_v),
      .rd_word(buf_w),
      .rd_ptr(rd_ptr[c])
    );

    saf_spe_gen u_spe (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .in_valid(ctrl_q.bypass ? RX_WORD_VALID[c] : buf_v),
      .in_word(ctrl_q.bypass ? in_w : buf_w),
      .just_en(ctrl_q.just_en),
      .out_valid(OUT_VALID[c]),
      .out_fp(FRAME_MARKER_OUT[c]),
      .out_spe(PAYLOAD_INDICATOR_OUT[c]),
      .out_data(OUT_DATA[c*SAF_DW +: SAF_DW])
    );
  end

  // ---------------------------------------------------------------
  // Checks on group engine 0 and channel 0; the edge check covers all four engines
  // ---------------------------------------------------------------
  property p_sync_load;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (st_q[0] == SY_IDLE && hits[0] != 8'h00 && !eng_rs[0])
      |=> (st_q[0] == SY_RUN && cnt_q[0] == SAF_SYNC_INIT);
  endproperty
  a_sync_load: assert property (p_sync_load)
    else $error("sync counter not loaded with initial value");

  property p_dec_one;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (st_q[0] == SY_RUN && !all_in[0] && !eng_rs[0])
      |=> cnt_q[0] == 5'($past(cnt_q[0]) - 5'h01);
  endproperty
  a_dec_one: assert property (p_dec_one)
    else $error("sync counter not stepping by one");

  property p_dec_two;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (st_q[0] == SY_RUN && all_in[0] && cnt_q[0] > 5'h02 && !eng_rs[0])
      |=> cnt_q[0] == 5'($past(cnt_q[0]) - 5'h02);
  endproperty
  a_dec_two: assert property (p_dec_two)
    else $error("sync counter not stepping by two");

  property p_start_zero;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (start[0] && members[0][0] && !rs_ch_rise[0] && !eng_rs[0])
      |=> (reading_q[0] && rd_ptr[0] == SAF_FIRST);
  endproperty
  a_start_zero: assert property (p_start_zero)
    else $error("group read did not begin at entry zero");

  property p_oos;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (oos_hit[0] && !wr_ctrl) |=> GROUP_OUT_OF_SYNC_FLAG[sidx[0]];
  endproperty
  a_oos: assert property (p_oos)
    else $error("out-of-sync flag not raised");

  property p_group_overflow_flag;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (grouped && mark[0] && reading_q[0] && rd_ptr[0] < fmin_q && !wr_ctrl)
      |=> GROUP_OVERFLOW_FLAG[sidx[grp_c[0]]];
  endproperty
  a_group_overflow_flag: assert property (p_group_overflow_flag)
    else $error("overflow flag not raised");

  property p_indep;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    (indep_load[0] && !rs_ch_rise[0])
      |=> (reading_q[0] && rd_ptr[0] == SAF_MID);
  endproperty
  a_indep: assert property (p_indep)
    else $error("lone channel read pointer not at middle");

  property p_resync;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    eng_rs[0] |=> (st_q[0] == SY_IDLE && cnt_q[0] == 5'h00
                   && seen_q[0] == 8'h00);
  endproperty
  a_resync: assert property (p_resync)
    else $error("resync did not rearm the group");

  property p_edge_only;
    @(posedge CLK_SYS) disable iff (SYS_RST)
    $stable(rs_grp_q) |-> eng_rs == 4'h0;
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("resync acted without a rising edge");
endmodule : saf_align_top

// >>> tb/saf_fabric_model.sv
/*
  Fabric-side consumer model: per channel, the cycle and word of the last
  output frame marker and the overhead run that starts with it.
  Assumes the alignment outputs on one clock, no back-pressure.
*/
module saf_fabric_model
  import saf_pkg::*;
(
  input wire logic clk,
  input wire logic [SAF_NCH-1:0] out_valid,
  input wire logic [SAF_NCH-1:0] out_fp,
  input wire logic [SAF_NCH-1:0] out_spe,
  input wire logic [SAF_NCH*SAF_DW-1:0] out_data,
  output int mk_cyc [SAF_NCH],
  output logic [SAF_DW-1:0] mk_dat [SAF_NCH],
  output int spe_low [SAF_NCH]
);
  timeunit 1ns;
  timeprecision 100ps;
  int cyc = 0;
  logic [SAF_NCH-1:0] run = '0;
  // ----------------
  // Capture
  // ----------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int c = 0; c < SAF_NCH; c++) begin
      if (out_valid[c] && out_fp[c]) begin
        mk_cyc[c] <= cyc;
        mk_dat[c] <= out_data[c*SAF_DW+:SAF_DW];
        spe_low[c] <= int'(!out_spe[c]);
        run[c] <= !out_spe[c];
      end else if (out_valid[c] && run[c]) begin
        spe_low[c] <= spe_low[c] + int'(!out_spe[c]);
        run[c] <= !out_spe[c];
      end
    end
  end
endmodule : saf_fabric_model

// >>> tb/tb_saf_align_top.sv
/*
  Testbench: register reads, lone channel, group sync, out-of-sync and
  overflow. Assumes all channel words share CLK_SYS, one word a cycle.
*/
module tb_saf_align_top
  import saf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, wr_s = 0, rd_s = 0;
  logic [SAF_NCH-1:0] rxv = '1, rxm = '0, ov, ofp, ospe;
  logic [SAF_NCH*SAF_DW-1:0] rxd = '0, odat;
  logic [3:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [6:0] group_overflow_flag, group_out_of_sync_flag;
  logic [31:0] mk_dat [SAF_NCH];
  int n = 0, num_errors = 0, samples_checked = 0, b;
  int tgt [SAF_NCH] = '{default: -1};
  int mk_cyc [SAF_NCH], spe_low [SAF_NCH];
  saf_align_top u_saf_align_top (.CLK_SYS(clk), .SYS_RST(rst),
    .RX_WORD_VALID(rxv), .RX_FRAME_MARK(rxm), .RX_WORD_DATA(rxd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
    .REG_RDATA(rdata), .OUT_VALID(ov), .FRAME_MARKER_OUT(ofp),
    .PAYLOAD_INDICATOR_OUT(ospe), .OUT_DATA(odat),
    .GROUP_OVERFLOW_FLAG(group_overflow_flag), .GROUP_OUT_OF_SYNC_FLAG(group_out_of_sync_flag));
  saf_fabric_model u_saf_fabric_model (.clk(clk), .out_valid(ov),
    .out_fp(ofp), .out_spe(ospe), .out_data(odat), .mk_cyc(mk_cyc),
    .mk_dat(mk_dat), .spe_low(spe_low));
  always #2 clk = ~clk;
  // ----------------
  // Channel words, one common rate for all channels
  // ----------------
  always @(posedge clk) begin
    n <= n + 1;
    for (int c = 0; c < SAF_NCH; c++) begin
      rxd[c*SAF_DW+:SAF_DW] <= {8'(c), 24'(n)};
      rxm[c] <= (n == tgt[c]);
    end
  end
  // ----------------
  // Access tasks
  // ----------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, rdata);
  endtask : rd
  // Markers on channels first.., skewed one cycle per channel
  task automatic mark(input int first, input int cnt);
    for (int c = first; c < first + cnt; c++) tgt[c] = n + 5 + c;
    repeat (120) @(posedge clk);
  endtask : mark
  task automatic resync(input logic [31:0] g);
    wr(SAF_R_RSGRP, 32'h0);
    wr(SAF_R_RSGRP, g);
  endtask : resync
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // ----------------
  // Tests
  // ----------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(SAF_R_CTRL, 32'h0);
    rd(SAF_R_STREN, 32'(SAF_STREN_RST));
    rd(SAF_R_FMIN, 32'(SAF_FMIN_RST));
    rd(4'h9, 32'h0);
    mark(0, 1);
    chk("lone marker word", {8'h0, 24'(tgt[0])}, mk_dat[0]);
    chk("overhead run", 32'd36, 32'(spe_low[0]));
    wr(SAF_R_CTRL, 32'(SAF_M_TWIN));
    resync(32'h2);
    mark(2, 1);
    chk("oos flags", 32'h2, 32'(group_out_of_sync_flag));
    rd(SAF_R_OOS, 32'h2);
    resync(32'h2);
    @(posedge clk);
    #1 chk("oos after resync", 32'h0, 32'(group_out_of_sync_flag));
    for (int m = 1; m < 4; m++) begin
      b = (m == 1) ? 0 : (m == 2) ? 4 : 6;
      wr(SAF_R_CTRL, 32'(m));
      resync(32'h1 << b);
      mark(0, 2 << (m - 1));
      for (int c = 0; c < (2 << (m - 1)); c++) begin
        chk("group cycle", 32'(mk_cyc[0]), 32'(mk_cyc[c]));
        chk("group word", {8'(c), 24'(tgt[c])}, mk_dat[c]);
      end
      chk("oos clear", 32'h0, 32'(group_out_of_sync_flag));
    end
    wr(SAF_R_STREN, 32'h7f);
    resync(32'h40);
    mark(0, 7);
    chk("disabled member", 32'(mk_cyc[0]), 32'(mk_cyc[6]));
    chk("oos disabled", 32'h0, 32'(group_out_of_sync_flag));
    wr(SAF_R_FMIN, 32'h1f);
    mark(0, 1);
    chk("group_overflow_flag octal", 32'h40, 32'(group_overflow_flag & 7'h40));
    wr(SAF_R_GROUP_OVERFLOW_FLAG, 32'h7f);
    #1 rd(SAF_R_GROUP_OVERFLOW_FLAG, 32'h0);
    wr(SAF_R_CTRL, 32'h0);
    wr(SAF_R_RSCH, 32'h1);
    mark(0, 1);
    b = tgt[0] + 4 + int'(SAF_MID);
    chk("lone latency", 32'(b), 32'(mk_cyc[0]));
    wr(SAF_R_CTRL, 32'h8);
    mark(0, 1);
    chk("bypass word", {8'h0, 24'(tgt[0])}, mk_dat[0]);
    chk("bypass latency", 32'(tgt[0] + 2), 32'(mk_cyc[0]));
    chk("bypass run", 32'd36, 32'(spe_low[0]));
    close_out();
  end
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule : tb_saf_align_top
